// [core/sbcra_spi_regs.sv]
// spi register access with mode effects and axi4-lite side registers
`timescale 1ns/1ps
`include "sbcra_regs.svh"
module sbcra_spi_regs import sbcra_pkg::*; #(
    parameter int HS_N = 4,
    parameter logic [7:0] FAMILY_ID = 8'h5a // arbitrary identity value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic spi_sclk,
    input wire logic spi_csn_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [2:0] wake_level,
    input wire sbcra_mode_t dev_mode,
    input wire logic [63:0][7:0] status_set,
    input wire logic [HS_N-1:0] hs_fault,
    input wire logic fail_trigger,
    output logic [1:0] mode_request,
    output logic [2:0] can_ctrl,
    output logic [1:0] lin_ctrl,
    output logic [1:0] second_supply_output_ctrl,
    output logic third_supply_output_on,
    output logic [HS_N-1:0] hs_on,
    output logic fail_output_n,
    output logic irq
);
    if (HS_N < 1 || HS_N > 8) begin : g_bad_hs_n
        $error("HS_N must be 1 to 8");
    end

    sbcra_state_t s_reg;
    sbcra_state_t s_next;
    logic cs_low, sclk_rise, sclk_fall, cs_fall, cs_rise, normal, mode_chg;
    logic ex, ex_t, ex_ctrl, ex_stat, ex_prot;
    logic [6:0] ex_a;
    logic [4:0] ex_ci;
    logic [5:0] ex_si;
    logic [7:0] ex_d, sif, rd_now, stat_sel;

    // register read mux for the spi response byte
    function automatic logic [7:0] rd(input logic [6:0] a);
        if (a <= `SBCRA_CTRL_LAST) begin
            return s_reg.ctrl[a[4:0]];
        end else if (a == `SBCRA_WK_LVL) begin
            return {5'h00, s_reg.wk_s2}; // live pin level
        end else if (a == `SBCRA_FAM_ID) begin
            return FAMILY_ID;
        end else if (a[6]) begin
            return s_reg.stat[a[5:0]];
        end
        return 8'h00;
    endfunction

    function automatic logic prot(input logic [6:0] a);
        return a == `SBCRA_WK_LVL || a == `SBCRA_FAM_ID || (a >= `SBCRA_SWK_FIRST && a <= `SBCRA_SWK_LAST);
    endfunction

    // edges found from the second synchroniser stage onward only
    assign cs_low = ~s_reg.csn_s[1];
    assign sclk_rise = cs_low & s_reg.sclk_s[1] & ~s_reg.sclk_s[2];
    assign sclk_fall = cs_low & ~s_reg.sclk_s[1] & s_reg.sclk_s[2];
    assign cs_fall = ~s_reg.csn_s[1] & s_reg.csn_s[2];
    assign cs_rise = s_reg.csn_s[1] & ~s_reg.csn_s[2];
    assign normal = dev_mode == SBCRA_NORMAL;
    assign mode_chg = dev_mode != s_reg.mode_prev;

    // decoded frame, valid at chip select release
    assign ex_a = s_reg.rx[6:0];
    assign ex_t = s_reg.rx[7];
    assign ex_d = s_reg.rx[15:8];
    assign ex_ci = ex_a[4:0];
    assign ex_si = ex_a[5:0];
    assign ex = cs_rise & (s_reg.cnt == `SBCRA_FRAME_BITS) & (dev_mode != SBCRA_RESTART);
    assign ex_ctrl = ex & (ex_a <= `SBCRA_CTRL_LAST);
    assign ex_stat = ex & ex_a[6] & (ex_a <= `SBCRA_STAT_LAST);
    assign ex_prot = prot(ex_a);
    assign rd_now = rd(s_reg.rx[15:9]);
    assign stat_sel = s_reg.stat[ex_si];

    // status information field, first response byte
    assign sif = {|s_reg.stat[`SBCRA_SI_HS_OL], |s_reg.stat[`SBCRA_SI_HS_OC],
                  |s_reg.stat[`SBCRA_SI_SUP2], |(s_reg.stat[`SBCRA_SI_WK1] | s_reg.stat[`SBCRA_SI_WK2]),
                  |s_reg.stat[`SBCRA_SI_BUS], |s_reg.stat[`SBCRA_SI_DEV],
                  |s_reg.stat[`SBCRA_SI_THERM], |s_reg.stat[`SBCRA_SI_SUP1]};

    // next state of the whole block
    always_comb begin
        logic [2:0] clr;
        logic [2:0] evt;
        logic [7:0] w;
        clr = 3'h0;
        evt = 3'h0;
        w = 8'h00;
        s_next = s_reg;
        // two-flop synchronisers for every pin
        s_next.sclk_s = {s_reg.sclk_s[1:0], spi_sclk};
        s_next.csn_s = {s_reg.csn_s[1:0], spi_csn_n};
        s_next.mosi_s = {s_reg.mosi_s[0], spi_mosi};
        s_next.wk_s1 = wake_level;
        s_next.wk_s2 = s_reg.wk_s1;
        // frame start: error flag shown before the first clock
        if (cs_fall) begin
            s_next.cnt = 5'h00;
            s_next.miso = s_reg.err;
            s_next.err = 1'b0;
            s_next.miso_oe = 1'b1;
            s_next.tx = {8'h00, sif};
        end
        // shift out on rising, sample on falling, lsb first
        if (sclk_rise) begin
            s_next.miso = s_reg.tx[0];
            s_next.tx = {1'b0, s_reg.tx[15:1]};
        end
        if (sclk_fall) begin
            s_next.rx = {s_reg.mosi_s[1], s_reg.rx[15:1]};
            if (s_reg.cnt != 5'h1f) begin
                s_next.cnt = s_reg.cnt + 5'h01;
            end
            // old content only; the write lands at frame end
            if (s_reg.cnt == 5'h07) begin
                s_next.tx[7:0] = rd_now;
            end
        end
        // a frame of wrong length is dropped and flagged
        if (cs_rise) begin
            s_next.miso_oe = 1'b0;
            if (s_reg.cnt != 5'h00 && s_reg.cnt != `SBCRA_FRAME_BITS) begin
                s_next.err = 1'b1;
                evt[1] = 1'b1;
            end
        end
        // control write, no check of failure flags
        if (ex_ctrl && ex_t) begin
            w = ex_d;
            if (!normal && ex_ci == `SBCRA_MS_CTRL) begin
                w[5:3] = s_reg.ctrl[`SBCRA_MS_CTRL][5:3];
            end
            if (!normal && ex_ci == `SBCRA_HS_CTRL) begin
                w = s_reg.ctrl[`SBCRA_HS_CTRL];
            end
            s_next.ctrl[ex_ci] = w;
        end
        // read and clear of a status byte
        if (ex_stat && ex_t && !ex_prot) begin
            s_next.stat[ex_si] = 8'h00;
        end
        evt[0] = ex;
        // mode change effects run after the host write so they win
        if (mode_chg) begin
            evt[2] = 1'b1;
            s_next.mode_prev = dev_mode;
            s_next.ctrl[`SBCRA_MS_CTRL][7:6] = dev_mode;
            unique case (dev_mode)
                SBCRA_SLEEP: begin
                    // active transceivers are parked wake-capable
                    if (s_next.ctrl[`SBCRA_BUS_CTRL][2:0] != `SBCRA_CAN_OFF &&
                        s_next.ctrl[`SBCRA_BUS_CTRL][2:0] != `SBCRA_CAN_WAKE) begin
                        s_next.ctrl[`SBCRA_BUS_CTRL][2:0] = `SBCRA_CAN_WAKE;
                    end
                    if (s_next.ctrl[`SBCRA_BUS_CTRL][4:3] != `SBCRA_LIN_OFF &&
                        s_next.ctrl[`SBCRA_BUS_CTRL][4:3] != `SBCRA_LIN_WAKE) begin
                        s_next.ctrl[`SBCRA_BUS_CTRL][4:3] = `SBCRA_LIN_WAKE;
                    end
                end
                SBCRA_RESTART: begin
                    // bus fields untouched: prior setting decides the state
                    s_next.ctrl[`SBCRA_HS_CTRL] = `SBCRA_CTRL_RST;
                    if (s_reg.standalone) begin
                        s_next.ctrl[`SBCRA_MS_CTRL][4:3] = 2'h0;
                    end
                end
                SBCRA_NORMAL, SBCRA_STOP: begin
                    // stop keeps bus fields, outputs stay on
                    // nothing rewritten here on purpose
                end
            endcase
        end
        // diagnosis stays live in every mode; a fault only turns off
        for (int i = 0; i < HS_N; i++) begin
            if (hs_fault[i]) begin
                s_next.ctrl[`SBCRA_HS_CTRL][i] = 1'b0;
            end
        end
        // sticky status sets win over a clear in the same cycle
        for (int i = 0; i < 64; i++) begin
            s_next.stat[i] = s_next.stat[i] | status_set[i];
        end
        s_next.stat[`SBCRA_SI_HS_OC][HS_N-1:0] = s_next.stat[`SBCRA_SI_HS_OC][HS_N-1:0] | hs_fault;
        // axi write channels, taken in either order
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.awready = 1'b0;
            s_next.aw_have = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.wready = 1'b0;
            s_next.w_have = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb0 = s_axi_wstrb[0];
        end
        if (s_reg.aw_have && s_reg.w_have) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `SBCRA_RESP_OKAY;
            unique case (s_reg.awaddr)
                `SBCRA_AXI_IRQ_EN: if (s_reg.wstrb0) s_next.irq_en = s_reg.wdata[2:0];
                `SBCRA_AXI_IRQ_CLR: if (s_reg.wstrb0) clr = s_reg.wdata[2:0];
                `SBCRA_AXI_CONFIG: begin
                    if (s_reg.wstrb0) begin
                        s_next.standalone = s_reg.wdata[0];
                        // fail output released only back in normal
                        if (s_reg.wdata[1] && normal) s_next.fail_n = 1'b1;
                    end
                end
                `SBCRA_AXI_IRQ_STAT, `SBCRA_AXI_STATE: s_next.bresp = `SBCRA_RESP_OKAY;
                default: s_next.bresp = `SBCRA_RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        // axi read, answer one cycle after the address
        if (s_reg.arready && s_axi_arvalid) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = `SBCRA_RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                `SBCRA_AXI_IRQ_STAT: s_next.rdata[2:0] = s_reg.irq_stat;
                `SBCRA_AXI_IRQ_EN: s_next.rdata[2:0] = s_reg.irq_en;
                `SBCRA_AXI_IRQ_CLR: s_next.rdata[2:0] = 3'h0;
                `SBCRA_AXI_CONFIG: s_next.rdata[0] = s_reg.standalone;
                `SBCRA_AXI_STATE: s_next.rdata[10:0] = {s_reg.mode_prev, s_reg.fail_n, s_reg.ctrl[`SBCRA_HS_CTRL]};
                default: s_next.rresp = `SBCRA_RESP_SLVERR;
            endcase
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // a new trigger beats a release in the same cycle
        if (fail_trigger) begin
            s_next.fail_n = 1'b0;
        end
        s_next.irq_stat = (s_reg.irq_stat & ~clr) | evt;
        s_next.irq = |(s_next.irq_stat & s_next.irq_en);
        if (!aresetn) begin
            s_next = '0;
            s_next.csn_s = 3'h7;
            s_next.fail_n = 1'b1;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
            s_next.arready = 1'b1;
        end
    end

    // the only state register
    always_ff @(posedge aclk) begin
        s_reg <= s_next;
    end

    // outputs straight from flops
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign spi_miso = s_reg.miso;
    assign spi_miso_oe = s_reg.miso_oe;
    assign mode_request = s_reg.ctrl[`SBCRA_MS_CTRL][7:6];
    assign third_supply_output_on = s_reg.ctrl[`SBCRA_MS_CTRL][5];
    assign second_supply_output_ctrl = s_reg.ctrl[`SBCRA_MS_CTRL][4:3];
    assign can_ctrl = s_reg.ctrl[`SBCRA_BUS_CTRL][2:0];
    assign lin_ctrl = s_reg.ctrl[`SBCRA_BUS_CTRL][4:3];
    assign hs_on = s_reg.ctrl[`SBCRA_HS_CTRL][HS_N-1:0];
    assign fail_output_n = s_reg.fail_n;
    assign irq = s_reg.irq;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ctrl_write: assert property (ex_ctrl && ex_t && normal && !mode_chg && ex_ci != `SBCRA_HS_CTRL
        |=> s_reg.ctrl[$past(ex_ci)] == $past(ex_d)) else $error("control write lost");
    a_ctrl_read: assert property (ex_ctrl && !ex_t && !mode_chg && !(|hs_fault) |=> $stable(s_reg.ctrl))
        else $error("read-only frame changed a control register");
    a_resp_old: assert property (sclk_fall && s_reg.cnt == 5'h07 |=> s_reg.tx[7:0] == $past(rd_now))
        else $error("response byte is not the old register content");
    a_stat_clear: assert property (ex_stat && ex_t && !ex_prot && status_set[ex_si] == 8'h00 && !(|hs_fault)
        |=> s_reg.stat[$past(ex_si)] == 8'h00) else $error("status byte not cleared");
    a_prot_keep: assert property (ex_stat && ex_t && ex_prot
        |=> s_reg.stat[$past(ex_si)] == ($past(stat_sel) | $past(status_set[ex_si])))
        else $error("protected status byte cleared");
    a_mode_field: assert property (mode_chg |=> s_reg.ctrl[`SBCRA_MS_CTRL][7:6] == $past(dev_mode))
        else $error("mode field not updated");
    a_diag_keep: assert property (mode_chg && dev_mode != SBCRA_NORMAL && !ex |=> s_reg.stat == ($past(s_reg.stat)
        | s_reg.stat)) else $error("diagnosis flags lost on mode entry");
    a_fail_keep: assert property (!s_reg.fail_n && !normal |=> !s_reg.fail_n)
        else $error("fail output released outside normal");
    a_stop_keep: assert property (mode_chg && dev_mode == SBCRA_STOP && !ex |=> $stable(s_reg.ctrl[`SBCRA_BUS_CTRL]))
        else $error("bus fields changed on stop entry");
    a_sleep_bus: assert property (mode_chg && dev_mode == SBCRA_SLEEP
        |=> s_reg.ctrl[`SBCRA_BUS_CTRL][2:0] inside {`SBCRA_CAN_OFF, `SBCRA_CAN_WAKE}
            && s_reg.ctrl[`SBCRA_BUS_CTRL][4:3] inside {`SBCRA_LIN_OFF, `SBCRA_LIN_WAKE})
        else $error("bus field active after sleep entry");
    a_cfg_normal: assert property (ex_ctrl && ex_t && !normal && ex_ci == `SBCRA_HS_CTRL && !mode_chg && !(|hs_fault)
        |=> $stable(s_reg.ctrl[`SBCRA_HS_CTRL])) else $error("switch config taken outside normal");
    a_hs_fault: assert property (hs_fault[0] |=> !s_reg.ctrl[`SBCRA_HS_CTRL][0] && !hs_on[0])
        else $error("faulty switch left on");
    a_restart_hs: assert property (mode_chg && dev_mode == SBCRA_RESTART |=> s_reg.ctrl[`SBCRA_HS_CTRL] == 8'h00)
        else $error("switch config kept through restart");
    a_restart_ign: assert property (cs_rise && dev_mode == SBCRA_RESTART && !mode_chg && !(|hs_fault)
        |=> $stable(s_reg.ctrl)) else $error("frame taken during restart");
    a_irq_level: assert property (s_reg.irq == |(s_reg.irq_stat & s_reg.irq_en))
        else $error("interrupt output disagrees with status");

    c_write: cover property (ex_ctrl && ex_t);
    c_clear: cover property (ex_stat && ex_t && !ex_prot);
    c_sleep: cover property (mode_chg && dev_mode == SBCRA_SLEEP);
    c_axi_wr: cover property (s_reg.bvalid && s_axi_bready);
endmodule // sbcra_spi_regs

// [common/sbcra_regs.svh]
// addresses, fields and reset values of the spi register access block
`ifndef SBCRA_REGS_SVH
`define SBCRA_REGS_SVH
// spi address map
`define SBCRA_CTRL_LAST 7'h1e
`define SBCRA_STAT_LAST 7'h7e
`define SBCRA_WK_LVL 7'h48
`define SBCRA_FAM_ID 7'h7e
`define SBCRA_SWK_FIRST 7'h58
`define SBCRA_SWK_LAST 7'h5d
// control register indices
`define SBCRA_MS_CTRL 5'h00
`define SBCRA_BUS_CTRL 5'h04
`define SBCRA_HS_CTRL 5'h14
// status register indices shown in the status information field
`define SBCRA_SI_SUP2 6'h00
`define SBCRA_SI_SUP1 6'h01
`define SBCRA_SI_THERM 6'h02
`define SBCRA_SI_DEV 6'h03
`define SBCRA_SI_BUS 6'h04
`define SBCRA_SI_WK1 6'h06
`define SBCRA_SI_WK2 6'h07
`define SBCRA_SI_HS_OC 6'h14
`define SBCRA_SI_HS_OL 6'h15
// transceiver field codes
`define SBCRA_CAN_OFF 3'h0
`define SBCRA_CAN_WAKE 3'h1
`define SBCRA_LIN_OFF 2'h0
`define SBCRA_LIN_WAKE 2'h1
// frame length in clocks
`define SBCRA_FRAME_BITS 5'h10
// axi4-lite map
`define SBCRA_AXI_IRQ_STAT 8'h00
`define SBCRA_AXI_IRQ_EN 8'h04
`define SBCRA_AXI_IRQ_CLR 8'h08
`define SBCRA_AXI_CONFIG 8'h0c
`define SBCRA_AXI_STATE 8'h10
`define SBCRA_RESP_OKAY 2'h0
`define SBCRA_RESP_SLVERR 2'h2
`define SBCRA_CTRL_RST 8'h00
`endif

// [common/sbcra_pkg.sv]
// types of the spi register access block
package sbcra_pkg;
    typedef enum logic [1:0] {
        SBCRA_NORMAL = 2'h0,
        SBCRA_STOP = 2'h1,
        SBCRA_SLEEP = 2'h3,
        SBCRA_RESTART = 2'h2
    } sbcra_mode_t;

    typedef struct packed {
        logic [31:0][7:0] ctrl;
        logic [63:0][7:0] stat;
        logic [2:0] sclk_s;
        logic [2:0] csn_s;
        logic [1:0] mosi_s;
        logic [2:0] wk_s1;
        logic [2:0] wk_s2;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0] cnt;
        logic miso;
        logic miso_oe;
        logic err;
        sbcra_mode_t mode_prev;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic irq;
        logic standalone;
        logic fail_n;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbcra_state_t;
endpackage

// [verification/sbcra_host.sv]
// spi master model standing in for the host controller
`timescale 1ns/1ps
module sbcra_host (
    output logic sclk,
    output logic csn_n,
    output logic mosi,
    input wire logic miso
);
    // idle clock low and select high between frames
    initial begin
        sclk = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b0;
    end
    // lsb first; a count other than 16 breaks framing on purpose
    task automatic xfer(input logic [15:0] di, input int nb, output logic [15:0] q);
        q = '0;
        #37 csn_n = 1'b0;
        #400;
        for (int i = 0; i < nb; i++) begin
            mosi = di[i];
            sclk = 1'b1;
            #400 sclk = 1'b0;
            #399 q[i] = miso;
            #1;
        end
        // released line shows the inverse, never the last bit
        mosi = ~mosi;
        #400 csn_n = 1'b1;
        #800;
    endtask
endmodule // sbcra_host

// [verification/tb.sv]
// self-checking bench of the spi register access block
`timescale 1ns/1ps
`include "sbcra_regs.svh"
module tb import sbcra_pkg::*;;
    localparam logic [7:0] FAM = 8'h3c; // arbitrary identity value
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic sclk, csn_n, mosi, miso, fail_trig, fail_n, irq, oe, oe_seen, third_supply_output;
    logic [7:0] awaddr, araddr, q, v, bv, sif;
    logic [31:0] wdata, rdata, rd, d, seed;
    logic [3:0] wstrb, hs_fault, hs_on;
    logic [1:0] bresp, rresp, r, lin, second_supply_output, mreq;
    logic [2:0] wake, can;
    logic [63:0][7:0] sset;
    logic [15:0] w;
    sbcra_mode_t mode;
    int failures, total_checks;
    // design and host model on its spi pins
    sbcra_spi_regs #(.HS_N(4), .FAMILY_ID(FAM)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .spi_sclk(sclk),
        .spi_csn_n(csn_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
        .wake_level(wake), .dev_mode(mode), .status_set(sset), .hs_fault(hs_fault),
        .fail_trigger(fail_trig), .mode_request(mreq), .can_ctrl(can), .lin_ctrl(lin),
        .second_supply_output_ctrl(second_supply_output), .third_supply_output_on(third_supply_output), .hs_on(hs_on), .fail_output_n(fail_n), .irq(irq)
    );
    sbcra_host u_host (.sclk(sclk), .csn_n(csn_n), .mosi(mosi), .miso(miso));
    // xorshift source from a fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // bus byte after sleep entry: active fields drop to wake-capable
    function automatic logic [7:0] slp(input logic [7:0] b);
        return {b[7:5], (b[4:3] > `SBCRA_LIN_WAKE) ? `SBCRA_LIN_WAKE : b[4:3],
            (b[2:0] > `SBCRA_CAN_WAKE) ? `SBCRA_CAN_WAKE : b[2:0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one axi4-lite transfer; waits on handshakes, never on a cycle count
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] x);
        logic ta, tw, tk;
        tk = 1'b0;
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, x};
        {awvalid, wvalid, arvalid, bready, rready} <= {wr, wr, !wr, 2'b11};
        // a hang is left to the watchdog
        while (!tk) begin
            @(negedge aclk);
            ta = (awvalid && awready) || (arvalid && arready);
            tw = wvalid && wready;
            tk = wr ? bvalid : rvalid;
            rd = rdata;
            r = wr ? bresp : rresp;
            @(posedge aclk);
            if (ta) {awvalid, arvalid} <= 2'b00;
            if (tw) wvalid <= 1'b0;
        end
        {bready, rready} <= 2'b00;
        @(negedge aclk);
    endtask
    task automatic fr(input logic [6:0] a, input logic t, input logic [7:0] x);
        u_host.xfer({x, t, a}, 16, w);
        {q, sif} = w;
    endtask
    // mode change plus one-cycle fault, fail and status pulses
    task automatic st(input sbcra_mode_t m, input logic [3:0] f, input logic t, input logic [7:0] s);
        @(posedge aclk);
        mode <= m;
        hs_fault <= f;
        fail_trig <= t;
        sset[1] <= s;
        sset[24] <= s; // selective-wake byte, must survive clears
        @(posedge aclk);
        hs_fault <= 4'h0;
        fail_trig <= 1'b0;
        sset <= '0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // about 30 frames of 15 us each, with margin
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
    initial begin
        failures = 0;
        total_checks = 0;
        seed = 32'hbe1c540f;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fail_trig, awaddr, araddr, wdata} = '0;
        {hs_fault, sset} = '0;
        wake = 3'h5;
        wstrb = 4'hf;
        mode = SBCRA_NORMAL;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axi(1'b0, 8'h14, 0);
        chk("unmapped", `SBCRA_RESP_SLVERR, r);
        axi(1'b1, 8'h14, 0);
        chk("wr_unmap", `SBCRA_RESP_SLVERR, r);
        // random writes answer with the value before them
        v = `SBCRA_CTRL_RST;
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            fr(7'h08, 1'b1, d[7:0]);
            chk("old_val", v, q);
            v = d[7:0];
        end
        fr(7'h08, 1'b0, ~v);
        // output enable must stand mid-frame and drop after it
        fork
            fr(7'h08, 1'b0, 8'h00);
            begin
                #5000;
                oe_seen = oe;
            end
        join
        chk("rd_only", v, q);
        chk("oe_frame", 1, oe_seen);
        chk("oe_idle", 0, oe);
        // event masked, then enabled, then cleared
        chk("irq_mask", 0, irq);
        axi(1'b1, `SBCRA_AXI_IRQ_EN, 7);
        chk("wr_okay", `SBCRA_RESP_OKAY, r);
        chk("irq_on", 1, irq);
        axi(1'b1, `SBCRA_AXI_IRQ_CLR, 7);
        chk("irq_off", 0, irq);
        // status read, read and clear, read again; protected bytes keep theirs
        d = rnd() | 32'h1;
        st(SBCRA_NORMAL, 4'h0, 1'b0, d[7:0]);
        fr(7'h41, 1'b0, 8'h00);
        chk("stat_rd", {1'b1, d[7:0]}, {sif[0], q});
        fr(7'h41, 1'b1, 8'h00);
        fr(7'h41, 1'b0, 8'h00);
        chk("stat_clr", 0, {sif[0], q});
        fr(7'h58, 1'b1, 8'h00);
        fr(7'h7e, 1'b1, 8'h00);
        chk("fam_id", FAM, q);
        fr(7'h58, 1'b0, 8'h00);
        chk("swk_keep", d[7:0], q);
        @(posedge aclk);
        wake <= d[10:8];
        fr(7'h48, 1'b1, 8'h00);
        fr(7'h48, 1'b0, 8'h00);
        chk("wake_lvl", d[10:8], q[2:0]);
        // a fault trips one switch; re-enable with its flag still set
        fr(7'h14, 1'b1, 8'h0f);
        st(SBCRA_NORMAL, 4'h1, 1'b0, 8'h00);
        chk("hs_trip", 4'he, hs_on);
        fr(7'h14, 1'b1, 8'h0f);
        fr(7'h54, 1'b0, 8'h00);
        chk("hs_reon", 5'h1f, {q[0], hs_on});
        // settings made in normal, then carried through the modes
        d = rnd();
        bv = (d[7:0] & 8'h0b) | 8'h14;
        fr(7'h04, 1'b1, bv);
        fr(7'h00, 1'b1, 8'h28);
        axi(1'b1, `SBCRA_AXI_CONFIG, 1);
        st(SBCRA_NORMAL, 4'h0, 1'b1, 8'h00);
        st(SBCRA_STOP, 4'h0, 1'b0, 8'h00);
        chk("mode_req", SBCRA_STOP, mreq);
        fr(7'h00, 1'b0, 8'h00);
        chk("mode_stop", 5'h0d, q[7:3]);
        fr(7'h04, 1'b0, 8'h00);
        chk("bus_stop", bv, q);
        fr(7'h54, 1'b0, 8'h00);
        chk("keep_stop", 6'h2f, {q[0], fail_n, hs_on});
        st(SBCRA_SLEEP, 4'h0, 1'b0, 8'h00);
        chk("bus_sleep", slp(bv), {3'h0, lin, can});
        fr(7'h14, 1'b1, 8'h00);
        st(SBCRA_SLEEP, 4'h2, 1'b0, 8'h00);
        chk("hs_sleep", 5'h1d, {third_supply_output, hs_on});
        st(SBCRA_RESTART, 4'h0, 1'b0, 8'h00);
        chk("hs_rst", 0, {second_supply_output, hs_on});
        chk("bus_rst", {slp(bv), 1'b0}, {3'h0, lin, can, fail_n});
        fr(7'h08, 1'b1, ~v);
        st(SBCRA_NORMAL, 4'h0, 1'b0, 8'h00);
        fr(7'h00, 1'b0, 8'h00);
        chk("mode_norm", 2'h0, q[7:6]);
        fr(7'h08, 1'b0, 8'h00);
        chk("rst_frame", v, q);
        // a short frame is dropped and flagged
        u_host.xfer({~v, 1'b1, 7'h08}, 15, w);
        fr(7'h08, 1'b0, 8'h00);
        chk("short", v, q);
        axi(1'b0, `SBCRA_AXI_IRQ_STAT, 0);
        chk("frame_err", 1, rd[1]);
        // fail output may be released only once back in normal
        axi(1'b1, `SBCRA_AXI_CONFIG, 3);
        chk("fail_rel", 1, fail_n);
        finish_test();
    end
endmodule // tb
